// >>> hdl/interval_timer.sv
// Up-counting interval timer, restarted whenever run drops.
// Assumes run is a registered level from the parent.
module interval_timer #(
    parameter int W = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [W-1:0] limit,
    output logic expired
);
    typedef struct packed {
        logic [W-1:0] count;
    } tmr_s;
    tmr_s s;
    tmr_s next_s;

    // Count only while running; dropping run restores the full interval
    always_comb begin
        next_s = s;
        if (!run) begin
            next_s.count = '0;
        end else if (s.count < limit) begin
            next_s.count = s.count + {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign expired = run && (s.count >= limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : interval_timer

// >>> hdl/level_compare.sv
// Registered magnitude comparator for digitised analog levels.
// Assumes both codes are synchronous to pclk.
module level_compare #(
    parameter int W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] level,
    input wire logic [W-1:0] threshold,
    output logic above
);
    typedef struct packed {
        logic above;
    } cmp_s;
    cmp_s s;
    cmp_s next_s;

    // One register stage filters combinational glitches on the codes
    always_comb begin
        next_s = s;
        next_s.above = level > threshold;
    end

    assign above = s.above;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : level_compare

// >>> hdl/overcurrent_fault_sequencer.sv
// Power switch supervisor: start-up sequencing, circuit breaker, flags.
// Assumes digitised current and voltage codes synchronous to pclk,
// and an APB master on the register side.

// Operation
// - Slew field picks turn-on slew factor
// - Clamp start-up current at the limit
// - Start-up timeout raises a start-up fault
// - Timeout sets bit 6 of vendor status A
// - Timeout drives fault pin, then retry policy
// - Compare load mirror against trip reference
// - Reference from internal DAC or pin
// - Overcurrent below short circuit starts blanking
// - Early recovery restarts blanking, no trip
// - Blanking expiry switches power off immediately
// - Blanking duration set by host register
// - After trip latch off or auto-restart
// - Transient sets transient overload flag
// - Transient writes one event log entry
// - Log pointer increments, wraps after six
// - Trip sets switch-off and other-fault bits
// - Trip sets upper status word bits
// - Trip sets output, input, vendor flags
// - Trip asserts alert unless sources masked
// - Trip drops power good, asserts fault unless masked
// - Thermal trip in start-up switches off
// - Low output voltage folds limit back
module overcurrent_fault_sequencer
    import ocf_pkg::*;
#(
    parameter int STARTUP_TIMEOUT = STARTUP_TIMEOUT_CYC,
    parameter int RETRY_DELAY = RETRY_DELAY_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic switch_turn_on,
    input wire logic [11:0] load_current_mirror,
    input wire logic [11:0] trip_reference_pin,
    input wire logic [11:0] device_current_mirror,
    input wire logic [11:0] output_voltage,
    input wire logic fully_on,
    input wire logic thermal_trip,
    input wire logic short_circuit,
    output logic switch_drive,
    output logic current_clamp,
    output logic [11:0] startup_limit,
    output logic [1:0] slew_scale,
    output logic [11:0] trip_reference_dac,
    output logic power_good_out,
    output logic fault_out_n,
    output logic smbalert_n
);
    typedef struct packed {
        power_state_e state;
        logic [15:0] dev_config;
        logic [11:0] ref_dac;
        logic [BLANK_W-1:0] blank;
        logic [2:0] alert_mask;
        logic [0:0] fault_mask;
        logic [15:0] status_word;
        logic [15:0] status_oi;
        logic [7:0] vendor_a;
        logic [7:0] vendor_b;
        logic [2:0] log_ptr;
        logic [LOG_DEPTH-1:0][7:0] log_id;
        logic [LOG_DEPTH-1:0][15:0] log_ts;
        logic [15:0] stamp;
        logic blanking_on;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic switch_drive;
        logic current_clamp;
        logic [11:0] startup_limit;
        logic power_good;
        logic fault_n;
        logic alert_n;
    } sup_s;
    sup_s s;
    sup_s next_s;

    logic setup;
    logic wr;
    logic log_hit;
    logic [2:0] log_idx;
    logic [11:0] ref_sel;
    logic over_oc;
    logic over_lim;
    logic below_fb;
    logic oc_run;
    logic oc_exp;
    logic su_exp;
    logic rt_exp;
    logic transient;
    logic trip;
    logic su_fail;
    logic hot;
    logic log_wr;

    // APB phase decode; a write lands only in the acknowledged access cycle
    assign setup = psel && !penable;
    assign wr = psel && penable && s.pready && pwrite;
    assign log_idx = paddr[4:2];
    assign log_hit = paddr[7:5] == LOG_PAGE && paddr[1:0] == 2'b00 && log_idx <= LOG_LAST;

    // Trip reference source select
    assign ref_sel = s.dev_config[CFG_EXT_REF] ? trip_reference_pin : s.ref_dac;

    // Circuit breaker comparator
    level_compare #(.W(12)) oc_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .level(load_current_mirror),
        .threshold(ref_sel),
        .above(over_oc)
    );

    // Start-up current limit comparator
    level_compare #(.W(12)) lim_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .level(device_current_mirror),
        .threshold(s.startup_limit),
        .above(over_lim)
    );

    // Foldback detector: output still below its threshold
    level_compare #(.W(12)) fb_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .level(FOLDBACK_VOUT),
        .threshold(output_voltage),
        .above(below_fb)
    );

    // Short circuits are left to the fast-trip path, so they do not run blanking
    assign oc_run = s.state == ST_ON && over_oc && !short_circuit;

    // Blanking timer; restarts from zero whenever the overload clears
    interval_timer #(.W(BLANK_W)) blank_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .run(oc_run),
        .limit(s.blank),
        .expired(oc_exp)
    );

    // Start-up timeout
    interval_timer #(.W(BLANK_W)) su_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .run(s.state == ST_RAMP),
        .limit(BLANK_W'(STARTUP_TIMEOUT)),
        .expired(su_exp)
    );

    // Auto-retry delay
    interval_timer #(.W(BLANK_W)) rt_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .run(s.state == ST_RETRY),
        .limit(BLANK_W'(RETRY_DELAY)),
        .expired(rt_exp)
    );

    // Fault events
    assign trip = s.state == ST_ON && oc_exp;
    assign transient = s.blanking_on && !over_oc && s.state == ST_ON;
    assign su_fail = s.state == ST_RAMP && su_exp && !fully_on;
    assign hot = s.state == ST_RAMP && thermal_trip;
    assign log_wr = transient && !s.dev_config[CFG_LOG_LOCK];

    // Next-state logic for the whole block
    always_comb begin
        next_s = s;
        next_s.stamp = s.stamp + 16'h0001;
        next_s.blanking_on = oc_run;
        // Read data is captured in setup so pready can rise in the first access cycle
        next_s.pready = setup;
        if (setup) begin
            next_s.pslverr = 1'b0;
            next_s.prdata = '0;
            case (paddr)
                OFS_CONFIG: next_s.prdata = {16'h0000, s.dev_config};
                OFS_REF_DAC: next_s.prdata = {20'h00000, s.ref_dac};
                OFS_BLANK: next_s.prdata = {8'h00, s.blank};
                OFS_ALERT_MASK: next_s.prdata = {29'h00000000, s.alert_mask};
                OFS_FAULT_MASK: next_s.prdata = {31'h00000000, s.fault_mask};
                OFS_STATUS_WORD: next_s.prdata = {16'h0000, s.status_word};
                OFS_STATUS_OI: next_s.prdata = {16'h0000, s.status_oi};
                OFS_VENDOR_A: next_s.prdata = {24'h000000, s.vendor_a};
                OFS_VENDOR_B: next_s.prdata = {24'h000000, s.vendor_b};
                OFS_LOG_PTR: next_s.prdata = {29'h00000000, s.log_ptr};
                default: begin
                    if (log_hit) begin
                        next_s.prdata = {8'h00, s.log_ts[log_idx], s.log_id[log_idx]};
                    end else begin
                        next_s.pslverr = 1'b1;
                    end
                end
            endcase
        end
        // Register writes; status registers are write-one-to-clear
        if (wr) begin
            case (paddr)
                OFS_CONFIG: next_s.dev_config = pwdata[15:0];
                OFS_REF_DAC: next_s.ref_dac = pwdata[11:0];
                OFS_BLANK: next_s.blank = pwdata[BLANK_W-1:0];
                OFS_ALERT_MASK: next_s.alert_mask = pwdata[2:0];
                OFS_FAULT_MASK: next_s.fault_mask = pwdata[0:0];
                OFS_STATUS_WORD: next_s.status_word = s.status_word & ~pwdata[15:0];
                OFS_STATUS_OI: next_s.status_oi = s.status_oi & ~pwdata[15:0];
                OFS_VENDOR_A: next_s.vendor_a = s.vendor_a & ~pwdata[7:0];
                OFS_VENDOR_B: next_s.vendor_b = s.vendor_b & ~pwdata[7:0];
                default: next_s.pslverr = s.pslverr;
            endcase
        end
        // Power sequencing
        case (s.state)
            ST_OFF: begin
                if (switch_turn_on) begin
                    next_s.state = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (!switch_turn_on) begin
                    next_s.state = ST_OFF;
                end else if (hot || su_fail) begin
                    next_s.state = ST_FAULT;
                end else if (fully_on) begin
                    next_s.state = ST_ON;
                end
            end
            ST_ON: begin
                if (!switch_turn_on) begin
                    next_s.state = ST_OFF;
                end else if (trip) begin
                    next_s.state = ST_FAULT;
                end
            end
            ST_FAULT: begin
                // Latched off until the turn-on signal is withdrawn, unless CFG_RETRY moves on to ST_RETRY
                if (!switch_turn_on) begin
                    next_s.state = ST_OFF;
                end else if (s.dev_config[CFG_RETRY]) begin
                    next_s.state = ST_RETRY;
                end
            end
            ST_RETRY: begin
                if (!switch_turn_on) begin
                    next_s.state = ST_OFF;
                end else if (rt_exp) begin
                    next_s.state = ST_RAMP;
                end
            end
            default: next_s.state = ST_OFF;
        endcase
        // Flag sets come after the clears so a same-cycle event wins
        if (su_fail) begin
            next_s.vendor_a[VA_STARTUP_TO] = 1'b1;
        end
        if (hot) begin
            next_s.vendor_a[VA_THERMAL] = 1'b1;
        end
        if (trip) begin
            next_s.status_word[SW_SWITCH_OFF] = 1'b1;
            next_s.status_word[SW_OTHER] = 1'b1;
            next_s.status_word[SW_OUTPUT] = 1'b1;
            next_s.status_word[SW_INPUT] = 1'b1;
            next_s.status_word[SW_POWER_BAD] = 1'b1;
            next_s.status_word[SW_UNKNOWN] = 1'b1;
            next_s.status_oi[OI_VOUT_UV] = 1'b1;
            next_s.status_oi[OI_OC_TRIP] = 1'b1;
            next_s.vendor_b[VB_POWER_BAD] = 1'b1;
        end
        if (transient) begin
            next_s.vendor_b[VB_TRANSIENT] = 1'b1;
        end
        // Event log; a locked log drops the entry and keeps the pointer
        if (log_wr) begin
            next_s.log_id[s.log_ptr] = LOG_ID_TRANSIENT;
            next_s.log_ts[s.log_ptr] = s.stamp;
            next_s.log_ptr = (s.log_ptr < LOG_LAST) ? s.log_ptr + 3'd1 : 3'd0;
        end
        // Outputs follow the next state so switch-off takes a single edge
        next_s.switch_drive = next_s.state == ST_RAMP || next_s.state == ST_ON;
        next_s.current_clamp = next_s.state == ST_RAMP && over_lim;
        next_s.startup_limit = below_fb ? FOLDBACK_LIMIT : STARTUP_LIMIT;
        next_s.power_good = next_s.state == ST_ON;
        next_s.fault_n = !((next_s.status_oi[OI_OC_TRIP] && !next_s.fault_mask[FM_OC_TRIP]) ||
            next_s.vendor_a[VA_STARTUP_TO]);
        next_s.alert_n = !((next_s.status_word[SW_INPUT] && !next_s.alert_mask[AM_INPUT]) ||
            (next_s.status_word[SW_POWER_BAD] && !next_s.alert_mask[AM_POWER_BAD]) ||
            (next_s.status_word[SW_OUTPUT] && !next_s.alert_mask[AM_OUTPUT]));
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.state <= ST_OFF;
            s.dev_config <= CONFIG_RST;
            s.ref_dac <= REF_DAC_RST;
            s.blank <= BLANK_RST;
            s.startup_limit <= STARTUP_LIMIT;
            s.fault_n <= 1'b1;
            s.alert_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Ports straight from flip-flops
    assign pready = s.pready;
    assign prdata = s.prdata;
    assign pslverr = s.pslverr;
    assign switch_drive = s.switch_drive;
    assign current_clamp = s.current_clamp;
    assign startup_limit = s.startup_limit;
    assign slew_scale = s.dev_config[CFG_SLEW_LO+1:CFG_SLEW_LO];
    assign trip_reference_dac = s.ref_dac;
    assign power_good_out = s.power_good;
    assign fault_out_n = s.fault_n;
    assign smbalert_n = s.alert_n;

    // Checks on the sequencing
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence trip_seq;
        s.state == ST_ON && oc_exp;
    endsequence

    sequence cfg_write_seq;
        wr && paddr == OFS_CONFIG;
    endsequence

    slew_write_a: assert property (cfg_write_seq |=> slew_scale == $past(pwdata[10:9]))
        else $error("slew scale not taken from config write");
    clamp_ramp_a: assert property (current_clamp == (s.state == ST_RAMP && $past(over_lim)))
        else $error("current clamp outside start-up");
    startup_fault_a: assert property (su_fail && switch_turn_on |=> s.vendor_a[6] && !switch_drive)
        else $error("start-up timeout not reported");
    fault_pin_a: assert property ($rose(s.vendor_a[VA_STARTUP_TO]) |-> !fault_out_n)
        else $error("fault pin not driven on start-up timeout");
    breaker_off_a: assert property (trip_seq and switch_turn_on |=> !switch_drive && !power_good_out)
        else $error("breaker did not switch off");
    blank_restart_a: assert property (s.state == ST_ON && !oc_run |=> blank_tmr.s.count == '0)
        else $error("blanking timer not restarted");
    transient_flag_a: assert property (transient |=> s.vendor_b[VB_TRANSIENT] && s.switch_drive)
        else $error("transient flag missing");
    log_wrap_a: assert property (log_wr |=>
        s.log_ptr == (($past(s.log_ptr) == 3'd6) ? 3'd0 : $past(s.log_ptr) + 3'd1))
        else $error("event log pointer step wrong");
    trip_flags_a: assert property (trip_seq |=> s.status_word[6] && s.status_word[0] &&
        s.status_word[15] && s.status_word[13] && s.status_oi[10] && s.vendor_b[4])
        else $error("trip flags missing");
    trip_alert_a: assert property (trip_seq and s.alert_mask != 3'b111 |=> !smbalert_n)
        else $error("alert not raised on trip");
endmodule : overcurrent_fault_sequencer

// >>> include/ocf_pkg.sv
// Shared constants for the overcurrent fault sequencer.
// Assumes a single 125 MHz clock domain and APB byte addressing.
package ocf_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_REF_DAC = 8'h04;
    localparam logic [7:0] OFS_BLANK = 8'h08;
    localparam logic [7:0] OFS_ALERT_MASK = 8'h0c;
    localparam logic [7:0] OFS_FAULT_MASK = 8'h10;
    localparam logic [7:0] OFS_STATUS_WORD = 8'h14;
    localparam logic [7:0] OFS_STATUS_OI = 8'h18;
    localparam logic [7:0] OFS_VENDOR_A = 8'h1c;
    localparam logic [7:0] OFS_VENDOR_B = 8'h20;
    localparam logic [7:0] OFS_LOG_PTR = 8'h24;
    localparam logic [2:0] LOG_PAGE = 3'h2;
    // Configuration fields
    localparam int CFG_RETRY = 0;
    localparam int CFG_EXT_REF = 1;
    localparam int CFG_LOG_LOCK = 2;
    localparam int CFG_SLEW_LO = 9;
    // Status, vendor and mask register fields
    localparam int SW_OTHER = 0;
    localparam int SW_SWITCH_OFF = 6;
    localparam int SW_UNKNOWN = 8;
    localparam int SW_POWER_BAD = 11;
    localparam int SW_INPUT = 13;
    localparam int SW_OUTPUT = 15;
    localparam int OI_VOUT_UV = 5;
    localparam int OI_OC_TRIP = 10;
    localparam int VA_THERMAL = 4;
    localparam int VA_STARTUP_TO = 6;
    localparam int VB_TRANSIENT = 0;
    localparam int VB_POWER_BAD = 4;
    localparam int AM_INPUT = 0;
    localparam int AM_POWER_BAD = 1;
    localparam int AM_OUTPUT = 2;
    localparam int FM_OC_TRIP = 0;
    // Reset values
    localparam logic [15:0] CONFIG_RST = 16'h0000;
    localparam logic [11:0] REF_DAC_RST = 12'h800;
    localparam int BLANK_W = 24;
    localparam logic [BLANK_W-1:0] BLANK_RST = 24'h061a80;
    // Event log
    localparam int LOG_DEPTH = 7;
    localparam logic [2:0] LOG_LAST = 3'd6;
    localparam logic [7:0] LOG_ID_TRANSIENT = 8'h01;
    // Start-up current limit codes
    localparam logic [11:0] STARTUP_LIMIT = 12'h600;
    localparam logic [11:0] FOLDBACK_LIMIT = 12'h200;
    localparam logic [11:0] FOLDBACK_VOUT = 12'h300;
    // Timing
    localparam int CLK_MHZ = 125;
    localparam int STARTUP_TIMEOUT_MS = 16;
    localparam int STARTUP_TIMEOUT_CYC = STARTUP_TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int RETRY_DELAY_MS = 8;
    localparam int RETRY_DELAY_CYC = RETRY_DELAY_MS * 1000 * CLK_MHZ;
    typedef enum logic [4:0] {
        ST_OFF = 5'b00001,
        ST_RAMP = 5'b00010,
        ST_ON = 5'b00100,
        ST_FAULT = 5'b01000,
        ST_RETRY = 5'b10000
    } power_state_e;
endpackage : ocf_pkg

// >>> testbench/overcurrent_fault_sequencer_tb_top.sv
// Self-checking bench: APB register tasks plus analog-side stimulus.
// Assumes the package is compiled first and the power stage model is present.
module overcurrent_fault_sequencer_tb_top import ocf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] W1C_REGS [4] = '{OFS_STATUS_WORD, OFS_STATUS_OI, OFS_VENDOR_A, OFS_VENDOR_B};
    localparam logic [31:0] SW_EXP = (32'h1 << SW_OTHER) | (32'h1 << SW_SWITCH_OFF) | (32'h1 << SW_UNKNOWN)
        | (32'h1 << SW_POWER_BAD) | (32'h1 << SW_INPUT) | (32'h1 << SW_OUTPUT);
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic switch_turn_on, fully_on, thermal_trip, stall, short_circuit;
    logic switch_drive, current_clamp, power_good_out, fault_out_n, smbalert_n;
    logic [11:0] load_current_mirror, trip_reference_pin, device_current_mirror, output_voltage;
    logic [11:0] startup_limit, trip_reference_dac;
    logic [1:0] slew_scale;
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;

    // Short timeout and retry counts keep the run brief
    overcurrent_fault_sequencer #(.STARTUP_TIMEOUT(50), .RETRY_DELAY(20)) u_overcurrent_fault_sequencer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .switch_turn_on(switch_turn_on),
        .load_current_mirror(load_current_mirror), .trip_reference_pin(trip_reference_pin),
        .device_current_mirror(device_current_mirror), .output_voltage(output_voltage), .fully_on(fully_on),
        .thermal_trip(thermal_trip), .short_circuit(short_circuit), .switch_drive(switch_drive),
        .current_clamp(current_clamp), .startup_limit(startup_limit), .slew_scale(slew_scale),
        .trip_reference_dac(trip_reference_dac), .power_good_out(power_good_out), .fault_out_n(fault_out_n),
        .smbalert_n(smbalert_n));

    power_stage_model u_power_stage_model (
        .pclk(pclk), .presetn(presetn), .switch_drive(switch_drive), .stall(stall), .fully_on(fully_on),
        .output_voltage(output_voltage), .device_current_mirror(device_current_mirror));

    // Clock, 8 ns period
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic summarize();
        if (fails == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // Watchdog: a hung handshake or state machine ends the run as a failure
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high, then released
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            fails++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    // Clearing every sticky flag lets the alert and fault pins return high
    task automatic clr();
        foreach (W1C_REGS[i]) wr(W1C_REGS[i], 32'hffffffff);
    endtask : clr

    task automatic pwr();
        @(posedge pclk);
        switch_turn_on <= 1'b1;
        for (int i = 0; i < 80 && power_good_out !== 1'b1; i++) @(posedge pclk);
        #1;
    endtask : pwr

    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, switch_turn_on, thermal_trip, stall, short_circuit} = '0;
        load_current_mirror = 12'h080;
        trip_reference_pin = 12'h100;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc(OFS_CONFIG, 32'(CONFIG_RST));
        rdc(OFS_REF_DAC, 32'(REF_DAC_RST));
        rdc(OFS_BLANK, 32'(BLANK_RST));
        chk(32'(fault_out_n & smbalert_n), 32'h1);
        rdc(8'hfc, 32'h0);
        chk(32'(err), 32'h1);
        for (int k = 0; k < 4; k++) begin
            wr(OFS_CONFIG, 32'(k) << CFG_SLEW_LO);
            chk(32'(slew_scale), 32'(k));
        end
        wr(OFS_CONFIG, 32'h0);
        wr(OFS_REF_DAC, 32'h100);
        wr(OFS_BLANK, 32'd10);
        chk(32'(trip_reference_dac), 32'h100);
        // Early in the ramp the output is low: folded limit and clamp expected
        @(posedge pclk);
        switch_turn_on <= 1'b1;
        repeat (4) @(posedge pclk);
        #1;
        chk(32'(startup_limit), 32'(FOLDBACK_LIMIT));
        chk(32'(current_clamp), 32'h1);
        pwr();
        chk(32'(power_good_out), 32'h1);
        chk(32'(startup_limit), 32'(STARTUP_LIMIT));
        // Seven short overloads: each shorter than the blanking time, never summed
        for (int t = 0; t < 7; t++) begin
            @(posedge pclk);
            load_current_mirror <= 12'h200;
            repeat (8) @(posedge pclk);
            load_current_mirror <= 12'h080;
            repeat (4) @(posedge pclk);
            #1;
            if (t == 0) begin
                rdc(OFS_LOG_PTR, 32'h1);
                apb(1'b0, 8'h40, 32'h0);
                chk({24'h0, rd[7:0]}, 32'(LOG_ID_TRANSIENT));
            end
        end
        chk(32'(switch_drive), 32'h1);
        // Overload under a short circuit belongs to the fast-trip path, so blanking must not run
        @(posedge pclk);
        short_circuit <= 1'b1;
        load_current_mirror <= 12'h200;
        repeat (20) @(posedge pclk);
        load_current_mirror <= 12'h080;
        repeat (2) @(posedge pclk);
        short_circuit <= 1'b0;
        #1;
        chk(32'(switch_drive), 32'h1);
        rdc(OFS_LOG_PTR, 32'h0);
        rdc(OFS_VENDOR_B, 32'h1 << VB_TRANSIENT);
        clr();
        // Persistent overload: unmasked on internal reference, then masked on the external pin
        for (int m = 0; m < 2; m++) begin
            wr(OFS_ALERT_MASK, m ? 32'h7 : 32'h0);
            wr(OFS_FAULT_MASK, 32'(m));
            wr(OFS_CONFIG, 32'(m) << CFG_EXT_REF);
            wr(OFS_REF_DAC, m ? 32'hfff : 32'h100);
            pwr();
            @(posedge pclk);
            load_current_mirror <= 12'h200;
            repeat (20) @(posedge pclk);
            #1;
            chk(32'(switch_drive), 32'h0);
            chk(32'(power_good_out), 32'h0);
            chk(32'(fault_out_n), 32'(m));
            chk(32'(smbalert_n), 32'(m));
            rdc(OFS_STATUS_WORD, SW_EXP);
            rdc(OFS_STATUS_OI, (32'h1 << OI_VOUT_UV) | (32'h1 << OI_OC_TRIP));
            rdc(OFS_VENDOR_B, 32'h1 << VB_POWER_BAD);
            @(posedge pclk);
            load_current_mirror <= 12'h080;
            switch_turn_on <= 1'b0;
            clr();
        end
        // Stalled ramp with auto-retry: timeout fault, then a fresh attempt
        wr(OFS_CONFIG, 32'h1 << CFG_RETRY);
        @(posedge pclk);
        stall <= 1'b1;
        switch_turn_on <= 1'b1;
        repeat (60) @(posedge pclk);
        #1;
        chk(32'(fault_out_n), 32'h0);
        rdc(OFS_VENDOR_A, 32'h1 << VA_STARTUP_TO);
        for (int i = 0; i < 40 && switch_drive !== 1'b1; i++) @(posedge pclk);
        #1;
        chk(32'(switch_drive), 32'h1);
        // Over-temperature while still ramping
        @(posedge pclk);
        thermal_trip <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        chk(32'(switch_drive), 32'h0);
        rdc(OFS_VENDOR_A, (32'h1 << VA_THERMAL) | (32'h1 << VA_STARTUP_TO));
        summarize();
    end
endmodule : overcurrent_fault_sequencer_tb_top

// >>> testbench/power_stage_model.sv
// Behavioural power stage on the analog side of the sequencer.
// Assumes switch_drive comes from the sequencer and that both share pclk.
module power_stage_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic switch_drive,
    input wire logic stall,
    output logic fully_on,
    output logic [11:0] output_voltage,
    output logic [11:0] device_current_mirror
);
    timeunit 1ns;
    timeprecision 1ps;

    // Output charges in steps; a stalled ramp never finishes, which is how a start-up timeout is provoked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_voltage <= 12'h000;
        end else if (!switch_drive) begin
            output_voltage <= 12'h000;
        end else if (!stall) begin
            output_voltage <= (output_voltage > 12'hf7f) ? 12'hfff : output_voltage + 12'h080;
        end
    end

    // Inrush stays above any start-up limit until the ramp completes, so the clamp must act
    assign fully_on = (output_voltage == 12'hfff);
    assign device_current_mirror = (switch_drive && !fully_on) ? 12'h700 : 12'h100;
endmodule : power_stage_model
